// [osc_ctrl.sv]
// Purpose: Oscillator control and status registers on an AHB-Lite slave.
// Assumes: Oscillator status pins are asynchronous to hclk.
// Notes: Interrupt status is cleared by reading it.
`timescale 1ns/10ps
// Notes on behaviour
// - Internal oscillator runs while enable bit is one; resets to zero.
// - Frequency ready flag reads one only when oscillator is at frequency.
// - Spread spectrum bit turns dithering on or off; resets to zero.
// - Seven-bit trim: larger value lowers frequency, smaller raises it.
// - External valid flag reads one when external oscillator is stable.
// - In either CMOS clock mode the external valid flag reads zero.
// - Mode decodes: 00x off, 010 CMOS, 011 CMOS/2, 100 RC, 101 C, 110 xtal/2.
// - Bit 3 of external control reads zero; software writes zero.
// - Three-bit drive level sets bias current; all eight codes accepted.
module osc_ctrl
   import osc_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic int_osc_at_freq,
   input wire logic ext_osc_stable,
   output logic int_osc_enable,
   output logic spread_spectrum_enable,
   output logic [6:0] int_osc_trim,
   output logic [2:0] ext_osc_drive_level,
   output logic [2:0] ext_osc_src,
   output logic irq
);
   logic [7:0] int_rsvd_and_en;
   logic [2:0] ext_osc_mode_sel;
   logic [1:0] sync_ready;
   logic [1:0] sync_stable;
   logic int_osc_freq_ready;
   logic ext_osc_valid;
   logic prev_ready;
   logic prev_valid;
   logic [1:0] irq_stat;
   logic [1:0] irq_mask;
   logic dp_write;
   logic dp_read;
   logic [7:0] dp_addr;
   logic [1:0] evt;
   logic stat_read;
   logic [1:0] stat_clr;
   logic [1:0] next_irq_stat;

   function automatic osc_src_t decode_mode(input logic [2:0] m);
      osc_src_t s;
      s = OSC_SRC_OFF;
      case (m)
         OSC_MODE_CMOS: s = OSC_SRC_CMOS;
         OSC_MODE_CMOS_DIV2: s = OSC_SRC_CMOS_DIV2;
         OSC_MODE_RC: s = OSC_SRC_RC;
         OSC_MODE_CAP: s = OSC_SRC_CAP;
         OSC_MODE_XTAL_DIV2: s = OSC_SRC_XTAL_DIV2;
         default: s = OSC_SRC_OFF;
      endcase
      return s;
   endfunction

   // Address phase capture; every access finishes with no wait state.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_write <= 1'b0;
         dp_read <= 1'b0;
         dp_addr <= 8'h00;
      end
      else if (hready)
      begin
         dp_write <= hsel && (htrans == OSC_HTRANS_NONSEQ) && hwrite;
         dp_read <= hsel && (htrans == OSC_HTRANS_NONSEQ) && !hwrite;
         dp_addr <= haddr;
      end
      else
      begin
         dp_write <= 1'b0;
         dp_read <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Two-stage synchronisers; only the second stage is looked at.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sync_ready <= 2'h0;
         sync_stable <= 2'h0;
      end
      else
      begin
         sync_ready <= {sync_ready[0], int_osc_at_freq};
         sync_stable <= {sync_stable[0], ext_osc_stable};
      end
   end

   // A disabled oscillator never reports ready.
   assign int_osc_freq_ready = sync_ready[1] && int_osc_enable;
   // CMOS modes have no valid detector, and a disabled circuit is unused.
   assign ext_osc_valid = sync_stable[1]
      && (ext_osc_src != OSC_SRC_CMOS) && (ext_osc_src != OSC_SRC_CMOS_DIV2)
      && (ext_osc_src != OSC_SRC_OFF);

   // A flag may only rise for a pin level that has crossed both stages.
   a_ready_synced: assert property (
      @(posedge hclk) disable iff (!hresetn)
      int_osc_freq_ready |-> $past(int_osc_at_freq, 2) && int_osc_enable)
      else $error("ready flag not backed by pin");

   a_valid_synced: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ext_osc_valid |-> $past(ext_osc_stable, 2))
      else $error("valid flag not backed by pin");

   a_cmos_valid_low: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (ext_osc_src == OSC_SRC_CMOS || ext_osc_src == OSC_SRC_CMOS_DIV2)
      |-> !ext_osc_valid)
      else $error("valid flag set in cmos mode");

   // Bit 3 of the external control word is not stored, so it reads zero.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         int_rsvd_and_en <= OSC_INT_CTRL_RESET;
         spread_spectrum_enable <= OSC_TRIM_RESET[OSC_SSE_BIT];
         int_osc_trim <= OSC_TRIM_RESET[6:0];
         ext_osc_mode_sel <= OSC_EXT_CTRL_RESET[6:4];
         ext_osc_drive_level <= OSC_EXT_CTRL_RESET[2:0];
         irq_mask <= 2'h0;
      end
      else if (dp_write)
      begin
         case (dp_addr)
            OSC_INT_CTRL_OFS:
               // Bits 7 and 5:0 are stored, bit 6 is not, so read-modify-write keeps bits 5:0.
               int_rsvd_and_en <= {hwdata[7], 1'b0, hwdata[5:0]};
            OSC_TRIM_OFS:
            begin
               spread_spectrum_enable <= hwdata[OSC_SSE_BIT];
               int_osc_trim <= hwdata[6:0];
            end
            OSC_EXT_CTRL_OFS:
            begin
               ext_osc_mode_sel <= hwdata[6:4];
               ext_osc_drive_level <= hwdata[2:0];
            end
            OSC_IRQ_MASK_OFS:
               irq_mask <= hwdata[1:0];
            default:
               irq_mask <= irq_mask;
         endcase
      end
   end

   a_trim_write: assert property (
      @(posedge hclk) disable iff (!hresetn)
      dp_write && dp_addr == OSC_TRIM_OFS
      |=> int_osc_trim == $past(hwdata[6:0])
      && spread_spectrum_enable == $past(hwdata[OSC_SSE_BIT]))
      else $error("trim write lost");

   a_drive_write: assert property (
      @(posedge hclk) disable iff (!hresetn)
      dp_write && dp_addr == OSC_EXT_CTRL_OFS
      |=> ext_osc_drive_level == $past(hwdata[2:0])
      && ext_osc_mode_sel == $past(hwdata[6:4]))
      else $error("external control write lost");

   a_rsvd_kept: assert property (
      @(posedge hclk) disable iff (!hresetn)
      dp_write && dp_addr == OSC_INT_CTRL_OFS
      |=> int_rsvd_and_en[5:0] == $past(hwdata[5:0]))
      else $error("reserved bits not stored");

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         int_osc_enable <= 1'b0;
         ext_osc_src <= 3'h0;
      end
      else
      begin
         int_osc_enable <= int_rsvd_and_en[OSC_ENABLE_BIT];
         ext_osc_src <= decode_mode(ext_osc_mode_sel);
      end
   end

   a_enable_follows: assert property (
      @(posedge hclk) disable iff (!hresetn)
      dp_write && dp_addr == OSC_INT_CTRL_OFS
      |-> ##2 int_osc_enable == $past(hwdata[OSC_ENABLE_BIT], 2))
      else $error("enable output did not follow write");

   a_enable_stops: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !int_rsvd_and_en[OSC_ENABLE_BIT] |=> !int_osc_enable)
      else $error("oscillator still enabled after clear");

   a_mode_seven_off: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ext_osc_mode_sel == 3'h7 |=> ext_osc_src == OSC_SRC_OFF)
      else $error("mode seven not treated as off");

   a_decode_off: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ext_osc_mode_sel[2:1] == 2'h0 |=> ext_osc_src == OSC_SRC_OFF)
      else $error("disabled mode not decoded as off");

   a_decode_cmos: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ext_osc_mode_sel == OSC_MODE_CMOS_DIV2
      |=> ext_osc_src == OSC_SRC_CMOS_DIV2)
      else $error("divided clock mode not decoded");

   a_decode_rc: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ext_osc_mode_sel == OSC_MODE_RC
      |=> ext_osc_src == OSC_SRC_RC)
      else $error("rc mode not decoded");

   a_decode_cap: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ext_osc_mode_sel == OSC_MODE_CAP
      |=> ext_osc_src == OSC_SRC_CAP)
      else $error("capacitor mode not decoded");

   a_decode_xtal: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ext_osc_mode_sel == OSC_MODE_XTAL_DIV2
      |=> ext_osc_src == OSC_SRC_XTAL_DIV2)
      else $error("crystal mode not decoded");

   // Rising ready and rising valid are the two interrupt events.
   assign evt = {ext_osc_valid && !prev_valid,
      int_osc_freq_ready && !prev_ready};
   assign stat_read = dp_read && (dp_addr == OSC_IRQ_STAT_OFS);
   // Only the bits that the read returned are cleared: an event that lands
   // between the address and the data phase was not seen and must survive.
   assign stat_clr = stat_read ? hrdata[1:0] : 2'h0;
   // A new event in the read cycle survives the clear.
   assign next_irq_stat = (irq_stat & ~stat_clr) | evt;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         prev_ready <= 1'b0;
         prev_valid <= 1'b0;
         irq_stat <= 2'h0;
         irq <= 1'b0;
      end
      else
      begin
         prev_ready <= int_osc_freq_ready;
         prev_valid <= ext_osc_valid;
         irq_stat <= next_irq_stat;
         irq <= |(next_irq_stat & irq_mask);
      end
   end

   a_stat_set_wins: assert property (
      @(posedge hclk) disable iff (!hresetn)
      evt != 2'h0 |=> (irq_stat & $past(evt)) == $past(evt))
      else $error("status event lost");

   a_stat_read_clears: assert property (
      @(posedge hclk) disable iff (!hresetn)
      stat_read && evt == 2'h0 |=> (irq_stat & $past(hrdata[1:0])) == 2'h0)
      else $error("status bits not cleared by read");

   a_irq_level: assert property (
      @(posedge hclk) disable iff (!hresetn)
      irq == |(irq_stat & $past(irq_mask)))
      else $error("interrupt level wrong");

   // Read data is captured in the address phase and stands through the
   // data phase; a status read therefore clears only what it returned.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (hready && hsel && (htrans == OSC_HTRANS_NONSEQ) && !hwrite)
      begin
         case (haddr)
            OSC_INT_CTRL_OFS:
               hrdata <= {24'h0, int_rsvd_and_en[7], int_osc_freq_ready,
                  int_rsvd_and_en[5:0]};
            OSC_TRIM_OFS:
               hrdata <= {24'h0, spread_spectrum_enable, int_osc_trim};
            OSC_EXT_CTRL_OFS:
               hrdata <= {24'h0, ext_osc_valid, ext_osc_mode_sel, 1'b0,
                  ext_osc_drive_level};
            OSC_IRQ_STAT_OFS:
               hrdata <= {30'h0, irq_stat};
            OSC_IRQ_MASK_OFS:
               hrdata <= {30'h0, irq_mask};
            default:
               hrdata <= 32'h0000_0000;
         endcase
      end
   end

   a_rsvd_bit_zero: assert property (
      @(posedge hclk) disable iff (!hresetn)
      hreadyout && $past(hsel && hready && htrans == OSC_HTRANS_NONSEQ
      && !hwrite && haddr == OSC_EXT_CTRL_OFS)
      |-> hrdata[OSC_RSVD_BIT] == 1'b0)
      else $error("reserved bit read as one");

   a_ready_read_low: assert property (
      @(posedge hclk) disable iff (!hresetn)
      $past(hsel && hready && htrans == OSC_HTRANS_NONSEQ && !hwrite
      && haddr == OSC_INT_CTRL_OFS && !int_osc_enable)
      |-> !hrdata[OSC_FREQ_READY_BIT])
      else $error("ready read as one while oscillator off");

   a_valid_read_low: assert property (
      @(posedge hclk) disable iff (!hresetn)
      $past(hsel && hready && htrans == OSC_HTRANS_NONSEQ && !hwrite
      && haddr == OSC_EXT_CTRL_OFS && ext_osc_src == OSC_SRC_OFF)
      |-> !hrdata[OSC_VALID_BIT])
      else $error("valid read as one while circuit unused");
endmodule

// [osc_ctrl_tb.sv]
// Purpose: Self-checking bench for the oscillator control registers.
// Assumes: Zero wait state slave; hready is fed from hreadyout.
// Notes: Waits of ten cycles cover the source delay and pin sync.
`timescale 1ns/10ps
module osc_ctrl_tb;
   import osc_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, rd;
   logic hreadyout, hresp, int_osc_at_freq, ext_osc_stable, irq;
   logic int_osc_enable, spread_spectrum_enable;
   logic [6:0] int_osc_trim;
   logic [2:0] ext_osc_drive_level, ext_osc_src, m;
   int n_fail = 0;
   int n_compared = 0;
   always #12.5 hclk = ~hclk;
   osc_ctrl osc_ctrl_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
      .int_osc_at_freq, .ext_osc_stable, .int_osc_enable,
      .spread_spectrum_enable, .int_osc_trim, .ext_osc_drive_level,
      .ext_osc_src, .irq);
   osc_src_model osc_src_model_i (.hclk, .int_osc_enable, .ext_osc_src,
      .int_osc_at_freq, .ext_osc_stable);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("Compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // The master holds each phase until hready is sampled high.
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= OSC_HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge hclk);
      #1;
   endtask
   function automatic logic [2:0] exp_src(input logic [2:0] c);
      if (c == 3'h2 || c == 3'h3)
         return c - 3'h1;
      return (c >= 3'h4 && c <= 3'h6) ? c - 3'h1 : 3'h0;
   endfunction
   initial
   begin
      repeat (5000) @(posedge hclk);
      n_fail++;
      finish_test();
   end
   initial
   begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      xfer(1'b0, OSC_INT_CTRL_OFS, 32'h0);
      check(rd, 32'h0);
      xfer(1'b0, OSC_TRIM_OFS, 32'h0);
      check(rd, 32'h40);
      xfer(1'b0, OSC_EXT_CTRL_OFS, 32'h0);
      check(rd, 32'h0);
      check({int_osc_enable, spread_spectrum_enable, irq, hresp}, 32'h0);
      check(hreadyout, 1'b1);
      check({int_osc_trim, ext_osc_src, ext_osc_drive_level}, 32'h1000);
      $display("test reset done");
      xfer(1'b1, OSC_IRQ_MASK_OFS, 32'h1);
      xfer(1'b1, OSC_INT_CTRL_OFS, 32'h15);
      xfer(1'b0, OSC_INT_CTRL_OFS, 32'h0);
      xfer(1'b1, OSC_INT_CTRL_OFS, rd | 32'h80);
      idle(10);
      check(int_osc_enable, 1'b1);
      check(irq, 1'b1);
      xfer(1'b0, OSC_INT_CTRL_OFS, 32'h0);
      check(rd, 32'hd5);
      xfer(1'b0, OSC_IRQ_STAT_OFS, 32'h0);
      check(rd, 32'h1);
      idle(2);
      check(irq, 1'b0);
      xfer(1'b0, OSC_INT_CTRL_OFS, 32'h0);
      xfer(1'b1, OSC_INT_CTRL_OFS, rd & 32'h7f);
      idle(10);
      check(int_osc_enable, 1'b0);
      xfer(1'b0, OSC_INT_CTRL_OFS, 32'h0);
      check(rd, 32'h15);
      $display("test internal oscillator done");
      xfer(1'b1, OSC_TRIM_OFS, 32'hc5);
      idle(2);
      check({spread_spectrum_enable, int_osc_trim}, 32'hc5);
      xfer(1'b1, OSC_TRIM_OFS, 32'h3a);
      xfer(1'b0, OSC_TRIM_OFS, 32'h0);
      check({16'h0, spread_spectrum_enable, int_osc_trim, rd[7:0]}, 32'h3a3a);
      $display("test trim done");
      xfer(1'b1, OSC_IRQ_MASK_OFS, 32'h0);
      for (int i = 0; i < 8; i++)
      begin
         m = i[2:0];
         xfer(1'b1, OSC_EXT_CTRL_OFS, {24'h0, 1'b1, m, 1'b0, m});
         idle(10);
         check(ext_osc_src, exp_src(m));
         check(ext_osc_drive_level, m);
         xfer(1'b0, OSC_EXT_CTRL_OFS, 32'h0);
         check(rd, {24'h0, m >= 3'h4 && m <= 3'h6, m, 1'b0, m});
      end
      check(irq, 1'b0);
      xfer(1'b0, OSC_IRQ_STAT_OFS, 32'h0);
      check(rd, 32'h2);
      xfer(1'b0, OSC_IRQ_STAT_OFS, 32'h0);
      check(rd, 32'h0);
      $display("test external modes done");
      xfer(1'b1, 8'hd0, 32'hff);
      xfer(1'b0, 8'hd0, 32'h0);
      check(rd, 32'h0);
      check(hresp, 1'b0);
      $display("test unmapped done");
      finish_test();
   end
endmodule

// [osc_pkg.sv]
// Purpose: Shared constants for the oscillator control register block.
// Assumes: AHB-Lite slave with 32-bit data, one word per register.
// Notes: Offsets are byte addresses; oscillator status arrives from pins.
package osc_pkg;
   localparam logic [7:0] OSC_EXT_CTRL_OFS = 8'hb1;
   localparam logic [7:0] OSC_INT_CTRL_OFS = 8'hb2;
   localparam logic [7:0] OSC_TRIM_OFS = 8'hb3;
   localparam logic [7:0] OSC_IRQ_STAT_OFS = 8'hc0;
   localparam logic [7:0] OSC_IRQ_MASK_OFS = 8'hc4;
   localparam logic [7:0] OSC_ADDR_STRIDE = 8'h04;
   localparam int OSC_ENABLE_BIT = 7;
   localparam int OSC_FREQ_READY_BIT = 6;
   localparam int OSC_SSE_BIT = 7;
   localparam int OSC_VALID_BIT = 7;
   localparam int OSC_MODE_LSB = 4;
   localparam int OSC_RSVD_BIT = 3;
   localparam logic [7:0] OSC_INT_CTRL_RESET = 8'h00;
   // Trim resets to mid-scale, because the calibrated value differs per part.
   localparam logic [7:0] OSC_TRIM_RESET = 8'h40;
   localparam logic [7:0] OSC_EXT_CTRL_RESET = 8'h00;
   localparam logic [2:0] OSC_MODE_OFF0 = 3'h0;
   localparam logic [2:0] OSC_MODE_OFF1 = 3'h1;
   localparam logic [2:0] OSC_MODE_CMOS = 3'h2;
   localparam logic [2:0] OSC_MODE_CMOS_DIV2 = 3'h3;
   localparam logic [2:0] OSC_MODE_RC = 3'h4;
   localparam logic [2:0] OSC_MODE_CAP = 3'h5;
   localparam logic [2:0] OSC_MODE_XTAL_DIV2 = 3'h6;
   localparam logic [1:0] OSC_HTRANS_NONSEQ = 2'h2;
   typedef enum logic [2:0] {
      OSC_SRC_OFF, OSC_SRC_CMOS, OSC_SRC_CMOS_DIV2,
      OSC_SRC_RC, OSC_SRC_CAP, OSC_SRC_XTAL_DIV2
   } osc_src_t;
endpackage

// [osc_src_model.sv]
// Purpose: Behavioural oscillator sources seen by the control block.
// Assumes: Both oscillators settle a fixed number of hclk cycles after start.
// Notes: Stable is also raised in CMOS modes, so masking is tested.
`timescale 1ns/10ps
module osc_src_model
#(
   parameter int DELAY = 4
)
(
   input wire logic hclk,
   input wire logic int_osc_enable,
   input wire logic [2:0] ext_osc_src,
   output logic int_osc_at_freq = 1'b0,
   output logic ext_osc_stable = 1'b0
);
   int n_int = 0;
   int n_ext = 0;
   logic [2:0] last_src = 3'h0;
   always @(posedge hclk)
   begin
      last_src <= ext_osc_src;
      n_int <= !int_osc_enable ? 0 : (n_int < DELAY ? n_int + 1 : n_int);
      if (ext_osc_src != last_src || ext_osc_src == 3'h0)
         n_ext <= 0;
      else if (n_ext < DELAY)
         n_ext <= n_ext + 1;
      int_osc_at_freq <= int_osc_enable && n_int >= DELAY;
      ext_osc_stable <= n_ext >= DELAY;
   end
endmodule
